// *** hw/csl_pkg.sv ***
`default_nettype none
package csl_pkg;
  // printed register indices; byte address is four times the index
  localparam logic [15:0] IDX_FBDIV    = 16'hf000;
  localparam logic [15:0] IDX_PRESCALE = 16'hf001;
  localparam logic [15:0] IDX_SRC      = 16'hf002;
  localparam logic [15:0] IDX_RUN      = 16'hf003;
  localparam logic [15:0] IDX_LOCK     = 16'hf004;
  localparam logic [15:0] IDX_CLKOUT   = 16'hf005;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hf008;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hf009;
  localparam int          ADDR_W       = 18;

  // field positions and widths
  localparam int FBDIV_W        = 7;
  localparam int PRESCALE_W     = 2;
  localparam int SRC_POS        = 0;
  localparam int RUN_POS        = 0;
  localparam int LOCK_POS       = 0;
  localparam int CLKOUT_EN_POS  = 0;
  localparam int CLKOUT_RATE_LO = 1;
  localparam int CLKOUT_RATE_W  = 2;
  localparam int IRQ_LOCKED_POS = 0;
  localparam int IRQ_LOST_POS   = 1;
  localparam int IRQ_W          = 2;

  // reset values
  localparam logic [FBDIV_W-1:0]       FBDIV_RST       = 7'h60;
  localparam logic [PRESCALE_W-1:0]    PRESCALE_RST    = 2'h0;
  localparam logic                     SRC_RST         = 1'b0;
  localparam logic                     RUN_RST         = 1'b0;
  localparam logic                     CLKOUT_EN_RST   = 1'b0;
  localparam logic [CLKOUT_RATE_W-1:0] CLKOUT_RATE_RST = 2'h0;
  localparam logic [IRQ_W-1:0]         IRQ_MASK_RST    = 2'h0;

  // source choice encodings
  localparam logic SRC_PIN   = 1'b0;
  localparam logic SRC_SYNTH = 1'b1;

  // timing
  localparam int PCLK_PERIOD_NS = 100;
  localparam int LOCK_TIME_NS   = 100_000;
  localparam int LOCK_CYCLES    = (LOCK_TIME_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CSL_ACQ_OFF,
    CSL_ACQ_SETTLE,
    CSL_ACQ_LOCKED
  } csl_acq_t;
endpackage
`default_nettype wire

// *** hw/csl_lock_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module csl_lock_timer #(
  parameter int CYCLES = csl_pkg::LOCK_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  input  wire logic enable,
  output logic      done
);
  import csl_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] TOP = CW'(CYCLES);

  logic [CW-1:0] cnt_q;

  if (CYCLES < 1) begin
    $error("csl_lock_timer: CYCLES must be at least 1");
  end

  // restarts from zero on clear so a fresh load never inherits old progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clear || !enable) begin
      cnt_q <= '0;
    end else if (cnt_q != TOP) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = enable && !clear && (cnt_q == TOP);
endmodule
`default_nettype wire

// *** hw/csl_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module csl_ctrl #(
  parameter int LOCK_CYCLES = csl_pkg::LOCK_CYCLES
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [csl_pkg::ADDR_W-1:0]         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               ext_clock_stable,
  output logic                                    core_clock_from_synth,
  output logic                                    synth_clock_on,
  output logic                                    dependent_clocks_idle,
  output logic                                    synth_in_tick,
  output logic [csl_pkg::FBDIV_W-1:0]             feedback_divide_value,
  output logic [csl_pkg::PRESCALE_W-1:0]          active_prescale,
  output logic                                    active_clkout_en,
  output logic [csl_pkg::CLKOUT_RATE_W-1:0]       active_clkout_rate,
  output logic                                    synth_locked,
  output logic                                    irq
);
  import csl_pkg::*;

  if (LOCK_CYCLES < 1) begin
    $error("csl_ctrl: LOCK_CYCLES must be at least 1");
  end

  // shadow registers written by software
  logic [FBDIV_W-1:0]       fbdiv_q;
  logic [PRESCALE_W-1:0]    prescale_q;
  logic                     source_choice_bit_q;
  logic                     run_q;
  logic                     run_prev_q;
  logic                     clkout_en_q;
  logic [CLKOUT_RATE_W-1:0] clkout_rate_q;
  logic [IRQ_W-1:0]         irq_stat_q;
  logic [IRQ_W-1:0]         irq_mask_q;

  // active configuration
  logic [FBDIV_W-1:0]       act_fbdiv_q;
  logic [PRESCALE_W-1:0]    act_prescale_q;
  logic                     act_src_q;
  logic                     act_clkout_en_q;
  logic [CLKOUT_RATE_W-1:0] act_clkout_rate_q;

  logic [31:0]              prdata_q;
  logic                     pslverr_q;
  logic [7:0]               pre_cnt_q;
  logic                     locked_q;
  csl_acq_t                 acq_q;

  logic [15:0]              word_idx;
  logic                     addr_aligned;
  logic                     wr_en;
  logic                     setup;
  logic                     load_strobe;
  logic                     acq_enable;
  logic                     timer_done;
  logic [7:0]               pre_top;
  logic                     ev_locked;
  logic                     ev_lost;
  logic [IRQ_W-1:0]         irq_set;
  logic                     mapped;

  assign word_idx     = paddr[ADDR_W-1:2];
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign setup        = psel && !penable;
  // no wait states: every register answers from a flop captured in setup
  assign pready       = 1'b1;
  assign wr_en        = psel && penable && pwrite && !pslverr_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;

  // unmapped or unaligned accesses answer with an error and drop the write
  always_comb begin
    mapped = 1'b0;
    if (addr_aligned) begin
      unique case (word_idx)
        IDX_FBDIV, IDX_PRESCALE, IDX_SRC, IDX_RUN,
        IDX_LOCK, IDX_CLKOUT, IDX_IRQ_STAT, IDX_IRQ_MASK: mapped = 1'b1;
        default:                                          mapped = 1'b0;
      endcase
    end
  end

  // read data and error are captured in the setup cycle, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !mapped;
      prdata_q  <= 32'h0000_0000;
      if (!pwrite && mapped) begin
        unique case (word_idx)
          IDX_FBDIV:    prdata_q[FBDIV_W-1:0]    <= fbdiv_q;
          IDX_PRESCALE: prdata_q[PRESCALE_W-1:0] <= prescale_q;
          IDX_SRC:      prdata_q[SRC_POS]        <= source_choice_bit_q;
          IDX_RUN:      prdata_q[RUN_POS]        <= run_q;
          IDX_LOCK:     prdata_q[LOCK_POS]       <= locked_q;
          IDX_CLKOUT: begin
            prdata_q[CLKOUT_EN_POS] <= clkout_en_q;
            prdata_q[CLKOUT_RATE_LO +: CLKOUT_RATE_W] <= clkout_rate_q;
          end
          IDX_IRQ_STAT: prdata_q[IRQ_W-1:0]      <= irq_stat_q;
          IDX_IRQ_MASK: prdata_q[IRQ_W-1:0]      <= irq_mask_q;
          default:      prdata_q                 <= 32'h0000_0000;
        endcase
      end
    end
  end

  // shadow writes; the lock index has no writable state at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fbdiv_q             <= FBDIV_RST;
      prescale_q          <= PRESCALE_RST;
      source_choice_bit_q <= SRC_RST;
      run_q               <= RUN_RST;
      clkout_en_q         <= CLKOUT_EN_RST;
      clkout_rate_q       <= CLKOUT_RATE_RST;
      irq_mask_q          <= IRQ_MASK_RST;
    end else if (wr_en) begin
      unique case (word_idx)
        IDX_FBDIV:    fbdiv_q             <= pwdata[FBDIV_W-1:0];
        IDX_PRESCALE: prescale_q          <= pwdata[PRESCALE_W-1:0];
        IDX_SRC:      source_choice_bit_q <= pwdata[SRC_POS];
        IDX_RUN:      run_q               <= pwdata[RUN_POS];
        IDX_CLKOUT: begin
          clkout_en_q   <= pwdata[CLKOUT_EN_POS];
          clkout_rate_q <= pwdata[CLKOUT_RATE_LO +: CLKOUT_RATE_W];
        end
        IDX_IRQ_MASK: irq_mask_q          <= pwdata[IRQ_W-1:0];
        default:      irq_mask_q          <= irq_mask_q;
      endcase
    end
  end

  // edge of the stored run bit, not of the bus write, so a rewrite of 1 is no edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_prev_q <= RUN_RST;
    end else begin
      run_prev_q <= run_q;
    end
  end

  assign load_strobe = run_q && !run_prev_q;

  // all settings move together on the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_fbdiv_q       <= FBDIV_RST;
      act_prescale_q    <= PRESCALE_RST;
      act_src_q         <= SRC_RST;
      act_clkout_en_q   <= CLKOUT_EN_RST;
      act_clkout_rate_q <= CLKOUT_RATE_RST;
    end else if (load_strobe) begin
      act_fbdiv_q       <= fbdiv_q;
      act_prescale_q    <= prescale_q;
      act_src_q         <= source_choice_bit_q;
      act_clkout_en_q   <= clkout_en_q;
      act_clkout_rate_q <= clkout_rate_q;
    end
  end

  // shadows may be rewritten while running; setting outputs keep the loaded copy, clock on and idle follow run_q
  assign core_clock_from_synth = (act_src_q == SRC_SYNTH);
  assign synth_clock_on        = run_q;
  assign dependent_clocks_idle = !run_q;
  assign feedback_divide_value = act_fbdiv_q;
  assign active_prescale       = act_prescale_q;
  assign active_clkout_en      = act_clkout_en_q && run_q;
  assign active_clkout_rate    = act_clkout_rate_q;

  // prescaler on the master clock: one tick every 1, 2, 4 or 8 cycles
  always_comb begin
    unique case (act_prescale_q)
      2'h0: pre_top = 8'h00;
      2'h1: pre_top = 8'h01;
      2'h2: pre_top = 8'h03;
      2'h3: pre_top = 8'h07;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= 8'h00;
    end else if (!run_q || load_strobe || pre_cnt_q >= pre_top) begin
      pre_cnt_q <= 8'h00;
    end else begin
      pre_cnt_q <= pre_cnt_q + 8'h01;
    end
  end

  // no tick on the load cycle, so a new ratio starts from a clean phase
  assign synth_in_tick = run_q && !load_strobe && (pre_cnt_q == pre_top);

  // a zero feedback divider cannot lock
  assign acq_enable = run_q && ext_clock_stable && (act_fbdiv_q != '0);

  // restarted on every load so new settings always get the full settle time
  csl_lock_timer #(
    .CYCLES (LOCK_CYCLES)
  ) u_lock_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (load_strobe),
    .enable  (acq_enable),
    .done    (timer_done)
  );

  // limitation: lock is a settle timer, the analog loop is not modelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_q <= CSL_ACQ_OFF;
    end else begin
      unique case (acq_q)
        CSL_ACQ_OFF: begin
          if (acq_enable) begin
            acq_q <= CSL_ACQ_SETTLE;
          end
        end
        CSL_ACQ_SETTLE: begin
          if (!acq_enable) begin
            acq_q <= CSL_ACQ_OFF;
          end else if (timer_done) begin
            acq_q <= CSL_ACQ_LOCKED;
          end
        end
        CSL_ACQ_LOCKED: begin
          if (!acq_enable || load_strobe) begin
            acq_q <= CSL_ACQ_OFF;
          end
        end
        // the spare code is never entered; fall back to off if it ever is
        default: acq_q <= CSL_ACQ_OFF;
      endcase
    end
  end

  // lock drops the cycle after any prerequisite goes away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= (acq_q == CSL_ACQ_LOCKED) && acq_enable && !load_strobe;
    end
  end

  assign synth_locked = locked_q;

  // events: lock gained, lock lost
  assign ev_locked = (acq_q == CSL_ACQ_LOCKED) && acq_enable && !load_strobe && !locked_q;
  assign ev_lost   = locked_q && !((acq_q == CSL_ACQ_LOCKED) && acq_enable && !load_strobe);
  assign irq_set   = {ev_lost, ev_locked};

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (irq_set[i]) begin
          irq_stat_q[i] <= 1'b1;
        end else if (wr_en && word_idx == IDX_IRQ_STAT && pwdata[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  // registered so the pin never glitches while status and mask settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

// *** testbench/csl_ctrl_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module csl_ctrl_assertions #(
  parameter int LOCK_CYCLES = 5
) (
  input wire logic                               pclk,
  input wire logic                               presetn,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [csl_pkg::ADDR_W-1:0]         paddr,
  input wire logic [31:0]                        pwdata,
  input wire logic [31:0]                        prdata,
  input wire logic                               pready,
  input wire logic                               pslverr,
  input wire logic                               ext_clock_stable,
  input wire logic                               core_clock_from_synth,
  input wire logic                               synth_clock_on,
  input wire logic                               dependent_clocks_idle,
  input wire logic                               synth_in_tick,
  input wire logic [csl_pkg::FBDIV_W-1:0]        feedback_divide_value,
  input wire logic [csl_pkg::PRESCALE_W-1:0]     active_prescale,
  input wire logic                               active_clkout_en,
  input wire logic [csl_pkg::CLKOUT_RATE_W-1:0]  active_clkout_rate,
  input wire logic                               synth_locked,
  input wire logic                               irq
);
  import csl_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // run seen low two edges back, high one edge back
  sequence s_run_rose;
    $past(synth_clock_on) && !$past(synth_clock_on, 2);
  endsequence
  sequence s_rd_setup;
    psel && !penable && !pwrite && paddr == {IDX_LOCK, 2'h0};
  endsequence
  property p_load;
    $changed({core_clock_from_synth, feedback_divide_value, active_prescale,
              active_clkout_rate}) |-> s_run_rose;
  endproperty
  property p_tick;
    synth_in_tick && active_prescale == 2'h3 |=> !synth_in_tick [*7];
  endproperty
  property p_lock_time;
    $rose(synth_locked) |-> $past(synth_clock_on, LOCK_CYCLES) && $past(ext_clock_stable, 3);
  endproperty
  property p_rd_lock;
    s_rd_setup |=> prdata == {31'h0, $past(synth_locked)} && !pslverr;
  endproperty
  property p_err;
    psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  property p_ready;
    pready;
  endproperty
  property p_idle;
    dependent_clocks_idle == !synth_clock_on;
  endproperty
  property p_quiet;
    !synth_clock_on |-> !synth_in_tick && !active_clkout_en;
  endproperty
  property p_off_unlock;
    !synth_clock_on [*3] |-> !synth_locked;
  endproperty
  property p_no_input;
    !ext_clock_stable [*3] |-> !synth_locked;
  endproperty
  a_load: assert property (p_load) else $error("config moved without run rise");
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
  a_lock_time: assert property (p_lock_time) else $error("lock too early");
  a_rd_lock: assert property (p_rd_lock) else $error("lock readback wrong");
  a_err: assert property (p_err) else $error("unaligned access not refused");
  a_ready: assert property (p_ready) else $error("pready low");
  a_idle: assert property (p_idle) else $error("idle flag wrong");
  a_quiet: assert property (p_quiet) else $error("clock activity while off");
  a_off_unlock: assert property (p_off_unlock) else $error("locked while off");
  a_no_input: assert property (p_no_input) else $error("locked without input");
endmodule
`default_nettype wire

// *** testbench/csl_clk_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module csl_clk_src_model (
  input  wire logic       pclk,
  input  wire logic       osc_on,
  input  wire logic [3:0] warmup,
  output logic            ext_clock_stable
);
  logic [3:0] cnt_q;
  // an oscillator is not trusted until it has run through its warm-up
  always_ff @(posedge pclk) begin
    if (!osc_on) cnt_q <= 4'h0;
    else if (cnt_q != warmup) cnt_q <= cnt_q + 4'h1;
  end
  assign ext_clock_stable = osc_on && cnt_q == warmup;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import csl_pkg::*;
  logic                     pclk = 1'b0;
  logic                     presetn = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [ADDR_W-1:0]        paddr = '0;
  logic [31:0]              pwdata = '0;
  logic [31:0]              prdata;
  logic                     pready, pslverr, ext_clock_stable, core_clock_from_synth;
  logic                     synth_clock_on, dependent_clocks_idle, synth_in_tick;
  logic                     active_clkout_en, synth_locked, irq;
  logic [FBDIV_W-1:0]       feedback_divide_value;
  logic [PRESCALE_W-1:0]    active_prescale;
  logic [CLKOUT_RATE_W-1:0] active_clkout_rate;
  logic                     osc_on = 1'b0;
  logic [32:0]              exp_q[$];
  int                       n_fail = 0;
  int                       n_tests = 0;
  int                       cyc = 0;
  int                       ticks;
  always #50 pclk = ~pclk;
  csl_clk_src_model u_csl_clk_src_model (.pclk, .osc_on, .warmup(4'h3), .ext_clock_stable);
  csl_ctrl #(.LOCK_CYCLES(5)) u_csl_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_clock_stable, .core_clock_from_synth,
    .synth_clock_on, .dependent_clocks_idle, .synth_in_tick, .feedback_divide_value,
    .active_prescale, .active_clkout_en, .active_clkout_rate, .synth_locked, .irq);
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'h0}, d, 33'h0);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'h0}, 32'h0, {1'b0, e});
  endtask
  // every completed transfer is held against the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready) chk({pslverr, prdata}, exp_q.pop_front());
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    logic [6:0] fb;
    logic [2:0] co;
    void'($urandom(32'h5ec6_2048));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_SRC, 0);
    rd(IDX_RUN, 0);
    rd(IDX_LOCK, 0);
    rd(IDX_FBDIV, 32'h0000_0060);
    chk({core_clock_from_synth, synth_locked, feedback_divide_value}, {2'h0, FBDIV_RST});
    $display("test reset done");
    fb = 7'($urandom_range(127, 1));
    co = 3'($urandom);
    osc_on <= 1'b1;
    wr(IDX_SRC, 1);
    wr(IDX_FBDIV, fb);
    wr(IDX_PRESCALE, 3);
    wr(IDX_CLKOUT, co);
    rd(IDX_FBDIV, fb);
    chk({core_clock_from_synth, feedback_divide_value}, {SRC_PIN, FBDIV_RST});
    wr(IDX_RUN, 1);
    repeat (3) @(posedge pclk);
    chk({core_clock_from_synth, feedback_divide_value, active_prescale, active_clkout_rate,
         active_clkout_en, dependent_clocks_idle}, {SRC_SYNTH, fb, 2'h3, co, 1'b0});
    wr(IDX_SRC, 0);
    repeat (3) @(posedge pclk);
    chk(core_clock_from_synth, SRC_SYNTH);
    $display("test shadow load done");
    // lock time varies, so the flag is polled under a bound
    for (int i = 0; i < 40 && synth_locked !== 1'b1; i++) @(posedge pclk);
    rd(IDX_LOCK, 1);
    wr(IDX_LOCK, 0);
    rd(IDX_LOCK, 1);
    rd(IDX_IRQ_STAT, 1);
    chk(irq, 0);
    wr(IDX_IRQ_MASK, 3);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    wr(IDX_IRQ_STAT, 1);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    wr(IDX_RUN, 0);
    repeat (3) @(posedge pclk);
    chk({synth_locked, synth_clock_on, dependent_clocks_idle, synth_in_tick, irq}, 5'h5);
    rd(IDX_IRQ_STAT, 2);
    wr(IDX_IRQ_STAT, 3);
    $display("test lock and interrupt done");
    for (int c = 0; c < 4; c++) begin
      wr(IDX_PRESCALE, c);
      wr(IDX_RUN, 1);
      repeat (4) @(posedge pclk);
      ticks = 0;
      repeat (32) begin
        @(posedge pclk);
        ticks += synth_in_tick;
      end
      chk(ticks, 32 >> c);
      wr(IDX_RUN, 0);
    end
    $display("test prescale done");
    osc_on <= 1'b0;
    wr(IDX_RUN, 1);
    repeat (20) @(posedge pclk);
    chk(synth_locked, 0);
    osc_on <= 1'b1;
    wr(IDX_RUN, 0);
    wr(IDX_FBDIV, 0);
    wr(IDX_RUN, 1);
    repeat (20) @(posedge pclk);
    chk(synth_locked, 0);
    apb(1'b0, {IDX_LOCK + 16'h2, 2'h0}, 32'h0, {1'b1, 32'h0});
    apb(1'b1, {IDX_SRC, 2'h2}, 32'h1, {1'b1, 32'h0});
    rd(IDX_SRC, 0);
    $display("test refusal done");
    // let the monitor take the last transfer before the verdict
    @(posedge pclk);
    chk(exp_q.size(), 0);
    summarize();
  end
endmodule
bind csl_ctrl csl_ctrl_assertions #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_clock_stable,
  .core_clock_from_synth, .synth_clock_on, .dependent_clocks_idle, .synth_in_tick,
  .feedback_divide_value, .active_prescale, .active_clkout_en, .active_clkout_rate,
  .synth_locked, .irq);
`default_nettype wire
